// file: dmd_pkg.sv
// package for the data memory space decoder: widths, bit positions,
// reset values, timing counts and shared types.
// assumes nothing of its surroundings.
package dmd_pkg;

  localparam int unsigned AUX_CTRL_W      = 8;
  localparam int unsigned ROUTE_SEL_BIT   = 1;
  localparam int unsigned LATCH_QUIET_BIT = 0;
  localparam logic [7:0]  AUX_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  AUX_CTRL_MASK   = 8'h03;

  localparam logic [7:0]  LOWER_RAM_TOP   = 8'h7F;
  localparam int unsigned AUX_RAM_BYTES   = 512;
  localparam logic [15:0] AUX_RAM_TOP     = 16'h01FF;

  localparam int unsigned KEY_BYTES       = 64;
  localparam logic [7:0]  KEY_ERASED      = 8'hFF;

  // latch strobe runs at one sixth of the oscillator: one pulse per 6 clocks
  localparam int unsigned LATCH_DIV       = 6;
  localparam logic [2:0]  LATCH_DIV_LAST  = 3'h5;

  typedef enum logic [1:0] {
    DMD_MODE_DIRECT   = 2'b00,
    DMD_MODE_INDIRECT = 2'b01,
    DMD_MODE_XRI      = 2'b10,
    DMD_MODE_XPTR     = 2'b11
  } dmd_mode_t;

  typedef enum logic [1:0] {
    DMD_TGT_LOW_RAM  = 2'b00,
    DMD_TGT_HIGH_RAM = 2'b01,
    DMD_TGT_SFR      = 2'b10,
    DMD_TGT_NONE     = 2'b11
  } dmd_tgt_t;

  typedef struct packed {
    logic      valid;
    dmd_mode_t mode;
    logic      write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dmd_req_t;

  typedef struct packed {
    logic       port_zero_oe_n;
    logic [7:0] port_zero_out;
    logic [7:0] port_two_out;
    logic       port_two_drive;
    logic       wr_strobe_n;
    logic       rd_strobe_n;
  } dmd_bus_t;

endpackage

// file: dmd_ram.sv
// single port byte memory used for the on-chip data rams.
// assumes one clock, one access per cycle, read data one cycle late.
`timescale 1ns/1ps
module dmd_ram #(
  parameter int unsigned DEPTH = 512,
  parameter int unsigned AW    = 9
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// file: dmd_lock.sv
// code protection: lock bits and the encryption key array.
// assumes lock bits are static straps sampled by the caller's reset.
`timescale 1ns/1ps
module dmd_lock (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       code_lock_first,
  input  wire logic       code_lock_second,
  input  wire logic       key_we,
  input  wire logic [5:0] key_addr,
  input  wire logic [7:0] key_wdata,
  input  wire logic [7:0] code_byte,
  input  wire logic [5:0] code_addr_low,
  output logic            verify_allowed,
  output logic            ext_code_fetch_block,
  output logic      [7:0] verify_byte
);

  logic [7:0] key_q [dmd_pkg::KEY_BYTES];
  logic [7:0] key_byte;

  // erased array is all ones; programming can only clear bits
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      // key is nonvolatile in silicon; reset here models a fresh part
      for (int i = 0; i < dmd_pkg::KEY_BYTES; i++)
      begin
        key_q[i] <= dmd_pkg::KEY_ERASED;
      end
    end
    else if (key_we)
    begin
      key_q[key_addr] <= key_q[key_addr] & key_wdata;
    end
  end

  assign key_byte = key_q[code_addr_low];

  // other lock combinations are undefined; treated as the nearest case
  always_comb
  begin
    verify_allowed       = !code_lock_second;
    ext_code_fetch_block = code_lock_first;
    // erased key xnor leaves the byte unchanged; else it encrypts
    verify_byte = ~(code_byte ^ key_byte);
    if (code_lock_second && !code_lock_first)
    begin
      ext_code_fetch_block = 1'b1;
    end
  end

endmodule

// file: dmd_top.sv
// data memory space decoder: internal ram, special function space,
// on-chip auxiliary ram, external multiplexed bus and latch strobe.
// assumes the core holds a request until done is seen, and that the
// external bus pins are resynchronised where they are sampled.
// Summary of operation
// - lower ram 00h-7Fh reached by direct and indirect accesses
// - upper ram 80h-FFh reached by indirect accesses only
// - direct access above 7Fh goes to special function space
// - indirect access above 7Fh goes to upper ram, not sfr
// - 512 byte auxiliary ram at 000h-1FFh via moves, route bit clear
// - route bit 1 of aux control: 0 on-chip ram, 1 external memory
// - auxiliary ram hits leave port zero and strobes untouched
// - pointer moves at 0200h-FFFFh still run an external bus cycle
// - indirect-register external move puts 8-bit address on port zero
// - pointer move: port two high byte, port zero low byte then data
// - external moves pulse write or read strobe by direction
// - bit 0 clear: strobe every sixth clock; set: only during moves
// - no lock bits: verify allowed, encrypted by key array
// - first lock bit: block code moves from external program memory
// - both lock bits: fetch block plus verify disabled
// - 64 byte key array reads all ones when unprogrammed
// - other lock combinations are undefined
`timescale 1ns/1ps
module dmd_top #(
  parameter int unsigned AUX_DEPTH = dmd_pkg::AUX_RAM_BYTES
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire dmd_pkg::dmd_req_t req,
  input  wire logic              code_move,
  input  wire logic              code_move_from_ext,
  input  wire logic              aux_ctrl_we,
  input  wire logic [7:0]        aux_ctrl_wdata,
  input  wire logic [7:0]        sfr_rdata,
  input  wire logic [7:0]        port_zero_in,
  input  wire logic              code_lock_first,
  input  wire logic              code_lock_second,
  input  wire logic              key_we,
  input  wire logic [5:0]        key_addr,
  input  wire logic [7:0]        key_wdata,
  input  wire logic [7:0]        code_byte,
  input  wire logic [5:0]        code_addr_low,
  output logic                   done,
  output logic [7:0]             rdata,
  output logic                   sfr_we,
  output logic                   sfr_re,
  output logic [7:0]             sfr_addr,
  output logic [7:0]             sfr_wdata,
  output logic [7:0]             aux_ctrl_rdata,
  output dmd_pkg::dmd_bus_t      bus,
  output logic                   latch_strobe,
  output logic                   verify_allowed,
  output logic                   code_fetch_block,
  output logic [7:0]             verify_byte
);

  typedef enum logic [2:0] {
    DMD_ST_IDLE  = 3'b000,
    DMD_ST_INT   = 3'b001,
    DMD_ST_ADDR  = 3'b010,
    DMD_ST_STRB  = 3'b011,
    DMD_ST_HOLD  = 3'b100,
    DMD_ST_DONE  = 3'b101
  } dmd_state_t;

  dmd_state_t        state_q;
  logic [7:0]        aux_ctrl_q;
  logic [2:0]        div_q;
  logic              div_tick;
  logic [7:0]        pz_meta_q;
  logic [7:0]        pz_sync_q;
  dmd_pkg::dmd_req_t req_q;
  dmd_pkg::dmd_tgt_t tgt_q;
  logic              aux_hit_q;
  logic              ext_q;
  logic              take;
  logic              route_ext;
  logic              iram_we;
  logic              on_chip_aux_data_ram_we;
  logic [7:0]        iram_rdata;
  logic [7:0]        on_chip_aux_data_ram_rdata;
  logic              lock_verify;
  logic              lock_block;
  logic [7:0]        lock_vbyte;
  logic              ale_pulse_q;

  // internal target by addressing mode and address
  function automatic dmd_pkg::dmd_tgt_t int_target(
    input dmd_pkg::dmd_mode_t mode,
    input logic [7:0]         addr
  );
    if (addr <= dmd_pkg::LOWER_RAM_TOP)
    begin
      int_target = dmd_pkg::DMD_TGT_LOW_RAM;
    end
    else if (mode == dmd_pkg::DMD_MODE_DIRECT)
    begin
      int_target = dmd_pkg::DMD_TGT_SFR;
    end
    else
    begin
      int_target = dmd_pkg::DMD_TGT_HIGH_RAM;
    end
  endfunction

  // auxiliary ram hit for an external move
  function automatic logic aux_hit(
    input dmd_pkg::dmd_mode_t mode,
    input logic [15:0]        addr,
    input logic               ext_sel
  );
    if (ext_sel)
    begin
      aux_hit = 1'b0;
    end
    else if (mode == dmd_pkg::DMD_MODE_XRI)
    begin
      // @ri reaches only 00h-FFh, all within the auxiliary ram
      aux_hit = 1'b1;
    end
    else
    begin
      aux_hit = (addr <= dmd_pkg::AUX_RAM_TOP);
    end
  endfunction

  assign route_ext = aux_ctrl_q[dmd_pkg::ROUTE_SEL_BIT];

  // control register: only the two low bits are stored
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aux_ctrl_q <= dmd_pkg::AUX_CTRL_RESET;
    end
    else if (aux_ctrl_we)
    begin
      aux_ctrl_q <= aux_ctrl_wdata & dmd_pkg::AUX_CTRL_MASK;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aux_ctrl_rdata <= dmd_pkg::AUX_CTRL_RESET;
    end
    else
    begin
      // reserved bits are undefined; zero is a legal choice
      aux_ctrl_rdata <= aux_ctrl_q;
    end
  end

  // port zero read data comes from outside the clock domain
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pz_meta_q <= 8'h00;
      pz_sync_q <= 8'h00;
    end
    else
    begin
      pz_meta_q <= port_zero_in;
      pz_sync_q <= pz_meta_q;
    end
  end

  // divide by six for the free running latch strobe
  always_ff @(posedge clk)
  begin
    if (reset || div_q == dmd_pkg::LATCH_DIV_LAST)
    begin
      div_q <= 3'h0;
    end
    else
    begin
      div_q <= div_q + 3'h1;
    end
  end

  assign div_tick = (div_q == dmd_pkg::LATCH_DIV_LAST);

  // request sequencing
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q   <= DMD_ST_IDLE;
      req_q     <= '0;
      tgt_q     <= dmd_pkg::DMD_TGT_NONE;
      aux_hit_q <= 1'b0;
      ext_q     <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        DMD_ST_IDLE:
        begin
          if (take)
          begin
            req_q <= req;
            if (req.mode == dmd_pkg::DMD_MODE_DIRECT ||
                req.mode == dmd_pkg::DMD_MODE_INDIRECT)
            begin
              tgt_q     <= int_target(req.mode, req.addr[7:0]);
              aux_hit_q <= 1'b0;
              ext_q     <= 1'b0;
              state_q   <= DMD_ST_INT;
            end
            else if (aux_hit(req.mode, req.addr, route_ext))
            begin
              tgt_q     <= dmd_pkg::DMD_TGT_NONE;
              aux_hit_q <= 1'b1;
              ext_q     <= 1'b0;
              state_q   <= DMD_ST_INT;
            end
            else
            begin
              tgt_q     <= dmd_pkg::DMD_TGT_NONE;
              aux_hit_q <= 1'b0;
              ext_q     <= 1'b1;
              state_q   <= DMD_ST_ADDR;
            end
          end
        end
        DMD_ST_INT:  state_q <= DMD_ST_DONE;
        DMD_ST_ADDR: state_q <= DMD_ST_STRB;
        DMD_ST_STRB: state_q <= DMD_ST_HOLD;
        DMD_ST_HOLD: state_q <= DMD_ST_DONE;
        DMD_ST_DONE: state_q <= DMD_ST_IDLE;
        default:     state_q <= DMD_ST_IDLE;
      endcase
    end
  end

  assign iram_we = (state_q == DMD_ST_INT) && req_q.write && !aux_hit_q &&
                   (tgt_q != dmd_pkg::DMD_TGT_SFR);
  assign on_chip_aux_data_ram_we = (state_q == DMD_ST_INT) && req_q.write && aux_hit_q;

  // upper ram and lower ram share one 256 byte array, sfr kept apart
  dmd_ram #(
    .DEPTH (256),
    .AW    (8)
  ) u_iram (
    .clk   (clk),
    .we    (iram_we),
    .addr  (req_q.addr[7:0]),
    .wdata (req_q.wdata),
    .rdata (iram_rdata)
  );

  dmd_ram #(
    .DEPTH (AUX_DEPTH),
    .AW    (9)
  ) u_on_chip_aux_data_ram (
    .clk   (clk),
    .we    (on_chip_aux_data_ram_we),
    .addr  (req_q.addr[8:0]),
    .wdata (req_q.wdata),
    .rdata (on_chip_aux_data_ram_rdata)
  );

  // special function space strobes
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sfr_we    <= 1'b0;
      sfr_re    <= 1'b0;
      sfr_addr  <= 8'h00;
      sfr_wdata <= 8'h00;
    end
    else
    begin
      sfr_we    <= take &&
                   req.mode == dmd_pkg::DMD_MODE_DIRECT &&
                   req.addr[7:0] > dmd_pkg::LOWER_RAM_TOP && req.write;
      sfr_re    <= take &&
                   req.mode == dmd_pkg::DMD_MODE_DIRECT &&
                   req.addr[7:0] > dmd_pkg::LOWER_RAM_TOP && !req.write;
      sfr_addr  <= req.addr[7:0];
      sfr_wdata <= req.wdata;
    end
  end

  // external bus: address phase, strobe phase, hold phase
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bus.port_zero_oe_n <= 1'b1;
      bus.port_zero_out  <= 8'h00;
      bus.port_two_out   <= 8'h00;
      bus.port_two_drive <= 1'b0;
      bus.wr_strobe_n    <= 1'b1;
      bus.rd_strobe_n    <= 1'b1;
    end
    else if (take &&
             (req.mode == dmd_pkg::DMD_MODE_XRI ||
              req.mode == dmd_pkg::DMD_MODE_XPTR) &&
             !aux_hit(req.mode, req.addr, route_ext))
    begin
      bus.port_zero_oe_n <= 1'b0;
      bus.port_zero_out  <= req.addr[7:0];
      if (req.mode == dmd_pkg::DMD_MODE_XPTR)
      begin
        bus.port_two_out   <= req.addr[15:8];
        bus.port_two_drive <= 1'b1;
      end
    end
    else if (ext_q && state_q == DMD_ST_ADDR)
    begin
      // address latched; port zero turns to data or releases for a read
      bus.port_zero_oe_n <= !req_q.write;
      bus.port_zero_out  <= req_q.wdata;
      bus.wr_strobe_n    <= !req_q.write;
      bus.rd_strobe_n    <= req_q.write;
    end
    else if (ext_q && state_q == DMD_ST_HOLD)
    begin
      bus.wr_strobe_n    <= 1'b1;
      bus.rd_strobe_n    <= 1'b1;
      bus.port_zero_oe_n <= 1'b1;
      bus.port_two_drive <= 1'b0;
    end
    // auxiliary hits never reach these branches, so pins stay put
  end

  // valid still up while done shows is the old request, not a new one
  assign take = (state_q == DMD_ST_IDLE) && req.valid && !done;

  // latch strobe: free running unless quiet bit set
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ale_pulse_q  <= 1'b0;
      latch_strobe <= 1'b0;
    end
    else
    begin
      ale_pulse_q <= take &&
                     (req.mode == dmd_pkg::DMD_MODE_XRI ||
                      req.mode == dmd_pkg::DMD_MODE_XPTR) &&
                     !aux_hit(req.mode, req.addr, route_ext);
      if (aux_ctrl_q[dmd_pkg::LATCH_QUIET_BIT])
      begin
        // quiet mode trades a free clock on the pin for lower emission
        latch_strobe <= ale_pulse_q || (code_move && div_tick);
      end
      else
      begin
        latch_strobe <= div_tick;
      end
    end
  end

  // answer to the core
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      done  <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      done <= (state_q == DMD_ST_DONE);
      if (state_q == DMD_ST_DONE)
      begin
        if (ext_q)
        begin
          rdata <= pz_sync_q;
        end
        else if (aux_hit_q)
        begin
          rdata <= on_chip_aux_data_ram_rdata;
        end
        else if (tgt_q == dmd_pkg::DMD_TGT_SFR)
        begin
          rdata <= sfr_rdata;
        end
        else
        begin
          rdata <= iram_rdata;
        end
      end
    end
  end

  dmd_lock u_lock (
    .clk                  (clk),
    .reset                (reset),
    .code_lock_first      (code_lock_first),
    .code_lock_second     (code_lock_second),
    .key_we               (key_we),
    .key_addr             (key_addr),
    .key_wdata            (key_wdata),
    .code_byte            (code_byte),
    .code_addr_low        (code_addr_low),
    .verify_allowed       (lock_verify),
    .ext_code_fetch_block (lock_block),
    .verify_byte          (lock_vbyte)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      verify_allowed   <= 1'b0;
      code_fetch_block <= 1'b1;
      verify_byte      <= 8'h00;
    end
    else
    begin
      verify_allowed   <= lock_verify;
      code_fetch_block <= lock_block && code_move &&
                          code_move_from_ext;
      verify_byte      <= lock_verify ? lock_vbyte : 8'h00;
    end
  end

endmodule

// file: dmd_checker.sv
// checker for dmd_top: routing, bus strobes, latch strobe, lock flags.
// bound to every dmd_top; sees its ports only.
`timescale 1ns/1ps
module dmd_checker #(
  parameter int unsigned AUX_DEPTH = 512
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire dmd_pkg::dmd_req_t req,
  input wire logic              code_move,
  input wire logic              code_move_from_ext,
  input wire logic [7:0]        aux_ctrl_rdata,
  input wire dmd_pkg::dmd_bus_t bus,
  input wire logic              done,
  input wire logic              sfr_we,
  input wire logic              sfr_re,
  input wire logic              latch_strobe,
  input wire logic              code_lock_first,
  input wire logic              code_lock_second,
  input wire logic              verify_allowed,
  input wire logic              code_fetch_block
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic xmv;
  logic ext;
  logic dsfr;
  logic fetch_q;
  // the block output is registered from the code move qualifiers
  always_ff @(posedge clk) fetch_q <= code_move && code_move_from_ext;
  assign xmv  = req.valid && req.mode[1];
  assign ext  = xmv && (aux_ctrl_rdata[1] ||
    (req.mode == dmd_pkg::DMD_MODE_XPTR && req.addr > 16'h01FF));
  assign dsfr = req.mode == dmd_pkg::DMD_MODE_DIRECT && req.addr[7];

  chk_aux_bus_quiet: assert property (xmv && !ext |->
    bus.wr_strobe_n && bus.rd_strobe_n && bus.port_zero_oe_n)
    else $error("aux ram access moved the bus");
  chk_direct_sfr: assert property ($rose(req.valid) && dsfr
    |-> ##[1:3] (sfr_we || sfr_re))
    else $error("direct access missed sfr space");
  chk_no_sfr: assert property (req.valid && !dsfr
    |-> !sfr_we && !sfr_re)
    else $error("sfr strobe on a non sfr access");
  chk_int_done: assert property ($rose(req.valid) && !ext
    |-> ##[2:4] done)
    else $error("internal access not done in time");
  chk_ext_strobe: assert property ($rose(req.valid) && ext
    |-> ##[1:4] (req.write ? !bus.wr_strobe_n && bus.rd_strobe_n
                           : !bus.rd_strobe_n && bus.wr_strobe_n))
    else $error("wrong or missing bus strobe");
  chk_addr_low: assert property ($rose(req.valid) && ext
    |-> ##[1:2] (!bus.port_zero_oe_n &&
                 bus.port_zero_out == req.addr[7:0]))
    else $error("low address not on port zero");
  chk_ptr_high: assert property (!bus.rd_strobe_n &&
    req.mode == dmd_pkg::DMD_MODE_XPTR |-> bus.port_two_drive &&
    bus.port_two_out == req.addr[15:8])
    else $error("pointer high byte not on port two");
  chk_latch_rate: assert property (
    latch_strobe && !aux_ctrl_rdata[0] |=> !latch_strobe [*5] ##1
    (latch_strobe || aux_ctrl_rdata[0]))
    else $error("latch strobe period wrong");
  chk_latch_quiet: assert property (
    (aux_ctrl_rdata[0] && !req.valid && !code_move) [*3]
    |-> !latch_strobe)
    else $error("latch strobe while quiet and idle");
  chk_lock_none: assert property (
    (!code_lock_first && !code_lock_second) [*4]
    |-> verify_allowed && !code_fetch_block)
    else $error("unlocked part refuses verify");
  chk_lock_both: assert property (
    (code_lock_first && code_lock_second) [*4]
    |-> !verify_allowed && (code_fetch_block == fetch_q))
    else $error("fully locked part allows verify");

  cov_ext_rd: cover property (!bus.rd_strobe_n);
  cov_ext_wr: cover property (!bus.wr_strobe_n);
  cov_sfr_wr: cover property (sfr_we);
endmodule

bind dmd_top dmd_checker #(.AUX_DEPTH(AUX_DEPTH)) u_chk (
  .clk(clk), .reset(reset), .req(req), .code_move(code_move),
  .code_move_from_ext(code_move_from_ext),
  .aux_ctrl_rdata(aux_ctrl_rdata), .bus(bus), .done(done),
  .sfr_we(sfr_we), .sfr_re(sfr_re), .latch_strobe(latch_strobe),
  .code_lock_first(code_lock_first),
  .code_lock_second(code_lock_second),
  .verify_allowed(verify_allowed), .code_fetch_block(code_fetch_block));

// file: dmd_ext_mem.sv
// external data memory model on the multiplexed port zero/two bus.
// assumes the same clock as dmd_top and registered bus outputs.
`timescale 1ns/1ps
module dmd_ext_mem (
  input  wire logic              clk,
  input  wire dmd_pkg::dmd_bus_t bus,
  output logic [7:0]             port_zero_in,
  output int                     n_cyc
);
  logic [7:0]  mem [logic [15:0]];
  logic [7:0]  lo_q = 8'h00;
  logic [7:0]  last_q = 8'h00;
  logic        idle_q = 1'b1;
  logic        idle;
  logic [15:0] a;
  assign idle = bus.wr_strobe_n && bus.rd_strobe_n;
  // @ri moves leave paging to port pins: no high byte seen here
  assign a = {bus.port_two_drive ? bus.port_two_out : 8'h00, lo_q};
  initial n_cyc = 0;
  // undriven bus toggles so a stale byte can never read as good
  always @*
    if (!bus.rd_strobe_n && mem.exists(a))
      port_zero_in = mem[a];
    else
      port_zero_in = ~last_q;
  always @(posedge clk)
  begin
    last_q <= port_zero_in;
    idle_q <= idle;
    if (idle && !bus.port_zero_oe_n)
      lo_q <= bus.port_zero_out;
    if (!bus.wr_strobe_n)
      mem[a] = bus.port_zero_out;
    if (idle_q && !idle)
      n_cyc <= n_cyc + 1;
  end
endmodule

// file: testbench.sv
// self-checking bench for dmd_top with an external memory model.
// assumes dmd_checker is bound and dmd_ext_mem sits on the bus.
`timescale 1ns/1ps
module testbench;
  localparam dmd_pkg::dmd_mode_t DIR = dmd_pkg::DMD_MODE_DIRECT;
  localparam dmd_pkg::dmd_mode_t IND = dmd_pkg::DMD_MODE_INDIRECT;
  localparam dmd_pkg::dmd_mode_t XRI = dmd_pkg::DMD_MODE_XRI;
  localparam dmd_pkg::dmd_mode_t XPT = dmd_pkg::DMD_MODE_XPTR;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  dmd_pkg::dmd_req_t req = '0;
  logic              aux_we = 1'b0;
  logic [7:0]        aux_wd = 8'h00;
  logic              lock1 = 1'b0;
  logic              lock2 = 1'b0;
  logic              key_we = 1'b0;
  logic [7:0]        key_wd = 8'h00;
  logic [7:0]        code_byte = 8'h00;
  logic              cm = 1'b0;
  logic              cm_ext = 1'b0;
  logic              done;
  logic              latch;
  logic              v_ok;
  logic              f_blk;
  logic [7:0]        rdata;
  logic [7:0]        sfr_addr;
  logic [7:0]        sfr_wdata;
  logic [7:0]        aux_rd;
  logic [7:0]        p0_in;
  logic [7:0]        vbyte;
  dmd_pkg::dmd_bus_t bus;
  logic [7:0]        d;
  int                fails = 0;
  int                n_tests = 0;
  int                cyc = 0;
  int                n_ext;
  int                c;

  always #2 clk = ~clk;

  dmd_top u_dut (
    .clk(clk), .reset(reset), .req(req), .code_move(cm),
    .code_move_from_ext(cm_ext), .aux_ctrl_we(aux_we),
    .aux_ctrl_wdata(aux_wd), .sfr_rdata(8'h77), .port_zero_in(p0_in),
    .code_lock_first(lock1), .code_lock_second(lock2),
    .key_we(key_we), .key_addr(6'h03), .key_wdata(key_wd),
    .code_byte(code_byte), .code_addr_low(6'h03), .done(done),
    .rdata(rdata), .sfr_we(), .sfr_re(), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .aux_ctrl_rdata(aux_rd), .bus(bus),
    .latch_strobe(latch), .verify_allowed(v_ok),
    .code_fetch_block(f_blk), .verify_byte(vbyte));

  dmd_ext_mem u_mem (.clk(clk), .bus(bus), .port_zero_in(p0_in),
    .n_cyc(n_ext));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until done is seen, dropped at the following edge
  task automatic acc(input dmd_pkg::dmd_mode_t m, input logic w,
                     input logic [15:0] a, input logic [7:0] wd);
    int k;
    @(posedge clk);
    req <= '{1'b1, m, w, a, wd};
    #1;
    for (k = 0; k < 20 && done !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1)
      cmp(8'h00, 8'h01);
    d = rdata;
    @(posedge clk);
    req.valid <= 1'b0;
  endtask

  task automatic aux_wr(input logic [7:0] v);
    @(posedge clk);
    aux_we <= 1'b1;
    aux_wd <= v;
    @(posedge clk);
    aux_we <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp(aux_rd, v);
  endtask

  task automatic do_reset(input logic f, input logic s);
    @(posedge clk);
    lock1 <= f;
    lock2 <= s;
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic count_latch();
    c = 0;
    repeat (30)
    begin
      @(posedge clk);
      #1;
      c += int'(latch);
    end
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fails++;
      end_sim();
    end
  end

  initial
  begin
    do_reset(1'b0, 1'b0);
    cmp(aux_rd, 8'h00);
    acc(DIR, 1'b1, 16'h007F, 8'h3C);
    acc(IND, 1'b0, 16'h007F, 8'h00);
    cmp(d, 8'h3C);
    acc(IND, 1'b1, 16'h0000, 8'hA5);
    acc(DIR, 1'b0, 16'h0000, 8'h00);
    cmp(d, 8'hA5);
    $display("test lower ram done");
    acc(IND, 1'b1, 16'h00A0, 8'h5A);
    acc(DIR, 1'b1, 16'h00A0, 8'hC3);
    cmp(sfr_addr, 8'hA0);
    cmp(sfr_wdata, 8'hC3);
    acc(IND, 1'b0, 16'h00A0, 8'h00);
    cmp(d, 8'h5A);
    acc(IND, 1'b1, 16'h00FF, 8'h96);
    acc(IND, 1'b0, 16'h00FF, 8'h00);
    cmp(d, 8'h96);
    acc(DIR, 1'b0, 16'h00A0, 8'h00);
    cmp(d, 8'h77);
    $display("test upper ram and sfr done");
    c = n_ext;
    acc(XRI, 1'b1, 16'h00A0, 8'h11);
    acc(XPT, 1'b1, 16'h01FF, 8'h22);
    acc(XPT, 1'b0, 16'h00A0, 8'h00);
    cmp(d, 8'h11);
    acc(XPT, 1'b0, 16'h01FF, 8'h00);
    cmp(d, 8'h22);
    cmp(8'(n_ext - c), 8'h00);
    acc(XPT, 1'b1, 16'h0200, 8'h44);
    cmp(u_mem.mem[16'h0200], 8'h44);
    acc(XPT, 1'b0, 16'h0200, 8'h00);
    cmp(d, 8'h44);
    cmp(8'(n_ext - c), 8'h02);
    $display("test aux ram done");
    aux_wr(8'h02);
    acc(XRI, 1'b1, 16'h00A0, 8'h33);
    cmp(u_mem.mem[16'h00A0], 8'h33);
    acc(XPT, 1'b1, 16'h1234, 8'h99);
    acc(XPT, 1'b0, 16'h1234, 8'h00);
    cmp(d, 8'h99);
    acc(XPT, 1'b0, 16'h00A0, 8'h00);
    cmp(d, 8'h33);
    $display("test external bus done");
    count_latch();
    cmp(8'(c), 8'h05);
    aux_wr(8'h03);
    count_latch();
    cmp(8'(c), 8'h00);
    $display("test latch strobe done");
    do_reset(1'b0, 1'b0);
    cmp(aux_rd, 8'h00);
    @(posedge clk);
    cm <= 1'b1;
    cm_ext <= 1'b1;
    code_byte <= 8'hA5;
    repeat (4) @(posedge clk);
    #1;
    cmp({6'h00, v_ok, f_blk}, 8'h02);
    cmp(vbyte, 8'hA5);
    @(posedge clk);
    key_we <= 1'b1;
    key_wd <= 8'h0F;
    @(posedge clk);
    key_we <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    cmp(vbyte, 8'h55);
    do_reset(1'b1, 1'b0);
    cmp({7'h00, f_blk}, 8'h01);
    @(posedge clk);
    cm_ext <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp({7'h00, f_blk}, 8'h00);
    @(posedge clk);
    cm_ext <= 1'b1;
    do_reset(1'b1, 1'b1);
    cmp({6'h00, v_ok, f_blk}, 8'h01);
    $display("test code lock done");
    end_sim();
  end
endmodule
